// ### tuner_regs_pkg.sv
// Shared constants and types for the tuner configuration and result registers
`default_nettype none

package tuner_regs_pkg;

	// Serial sub addresses
	localparam logic [7:0] ADDR_SPECIAL = 8'h06;
	localparam logic [7:0] ADDR_IF_GAIN = 8'h07;
	localparam logic [7:0] ADDR_THRESH  = 8'h0b;
	localparam logic [7:0] ADDR_RESULT  = 8'h82;
	localparam logic [7:0] ADDR_MISC    = 8'h83;
	localparam int         ADDR_RD_BIT  = 7;

	// Frame lengths in bits
	localparam logic [4:0] ADDR_BITS = 5'h08;
	localparam logic [4:0] BYTE_BITS = 5'h08;
	localparam logic [4:0] WORD_BITS = 5'h10;
	localparam int         SHIFT_W   = 24;

	// Special configuration byte fields
	localparam int SP_AUX_BIT  = 7;
	localparam int SP_LO_BIT   = 6;
	localparam int SP_AGC_HI   = 5;
	localparam int SP_AGC_LO   = 4;
	localparam int SP_TRIM_HI  = 3;
	localparam int SP_TRIM_LO  = 0;

	// Gain code field, upper nibble ignored
	localparam int GAIN_HI = 3;
	localparam int GAIN_LO = 0;

	// Threshold word fields
	localparam int THR_FS_HI = 14;
	localparam int THR_FS_LO = 8;
	localparam int THR_MP_HI = 6;
	localparam int THR_MP_LO = 0;

	// Result word fields
	localparam int RES_BELOW_BIT = 15;
	localparam int RES_OUT_BIT   = 7;

	// Misc result byte fields
	localparam int MISC_BELOW_BIT = 7;
	localparam int MISC_OUT_BIT   = 6;
	localparam int MISC_FS_BIT    = 5;
	localparam int MISC_MP_BIT    = 4;
	localparam logic [3:0] MISC_RSVD = 4'h0;

	localparam int MEAS_W = 7;

	// Reset values
	localparam logic [7:0] RST_SPECIAL = 8'h00;
	localparam logic [3:0] RST_GAIN    = 4'h0;
	localparam logic [6:0] RST_THR     = 7'h00;

	// Bus line spike suppression
	localparam int SPIKE_NS      = 50;
	localparam int CLK_PERIOD_NS = 40;
	localparam int SPIKE_CYC     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ADDR  = 2'b01,
		ST_WDATA = 2'b11,
		ST_RDATA = 2'b10
	} frame_st_t;

endpackage : tuner_regs_pkg

`default_nettype wire

// ### bus_lines_if.sv
// Filtered serial bus line levels passed from the input filter to the register logic
`timescale 1ns/1ps
`default_nettype none

interface bus_lines_if;
	logic scl;
	logic sda;
	logic ena;
	modport src (output scl, output sda, output ena);
	modport dst (input scl, input sda, input ena);
endinterface : bus_lines_if

`default_nettype wire

// ### bus_spike_filter.sv
// Three-stage synchroniser and spike filter for the serial bus input pins
`timescale 1ns/1ps
`default_nettype none

module bus_spike_filter (
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	// Raw pins
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic ena_i,
	// Filtered levels
	bus_lines_if.src  lines
);
	import tuner_regs_pkg::*;

	localparam int W  = 3;
	localparam int CW = 2;
	localparam logic [CW-1:0] ACCEPT_CNT = CW'(SPIKE_CYC - 1);

	typedef struct packed {
		logic [W-1:0]         s1;
		logic [W-1:0]         s2;
		logic [W-1:0]         s3;
		logic [W-1:0]         out;
		logic [W-1:0][CW-1:0] cnt;
	} filt_t;

	filt_t r;
	filt_t n;

	always_comb begin
		n    = r;
		n.s1 = {ena_i, sda_i, scl_i};
		n.s2 = r.s1;
		n.s3 = r.s2;
		// A level must agree over enough samples to outlast any spike
		for (int i = 0; i < W; i++) begin
			if (r.s2[i] == r.s3[i] && r.s3[i] != r.out[i]) begin
				if (r.cnt[i] == ACCEPT_CNT) begin
					n.out[i] = r.s3[i];
					n.cnt[i] = '0;
				end else begin
					n.cnt[i] = r.cnt[i] + 1'b1;
				end
			end else begin
				n.cnt[i] = '0;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign lines.scl = r.out[0];
	assign lines.sda = r.out[1];
	assign lines.ena = r.out[2];

	a_spike_reject: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		((r.out ^ $past(r.out)) & (($past(r.s3) ^ r.out) | ($past(r.s3, 2) ^ r.out))) == '0)
		else $error("filtered level changed without stable samples");

endmodule : bus_spike_filter

`default_nettype wire

// ### tuner_config_result_regs.sv
// Tuner specials, gain, threshold and result registers behind a three-wire serial port
//
// Functional notes
// - Specials D7 aux crystal out, D6 LO divide, D5:D4 gain threshold 15..60mV.
// - Specials D3:D0 crystal load trim, code n gives n picofarads.
// - Gain register ignores D7:D4; D3:D0 is the IF gain code.
// - Misc D5 set when field strength exceeds threshold D14:D8, else cleared.
// - Misc D4 set when multipath exceeds threshold D6:D0, else cleared.
// - Result word D14:D8 carries multipath result, MSB at D14.
// - Result word D6:D0 carries field-strength result, MSB at D6.
// - Result D7 flags outside window; D15 then says below (1) or above.
// - Misc D6 flags outside window; D7 then says below (1) or above.
// - Bus line spikes up to 50 ns are never taken as transitions.
`timescale 1ns/1ps
`default_nettype none

module tuner_config_result_regs (
	// Clock and reset
	input  wire logic                             mclk_i,
	input  wire logic                             nrst_i,
	// Serial bus pins
	input  wire logic                             scl_i,
	input  wire logic                             sda_i,
	input  wire logic                             bus_frame_enable_i,
	output logic                                  data_out_o,
	output logic                                  data_out_en_o,
	// Measurements from converters and IF counter
	input  wire logic [tuner_regs_pkg::MEAS_W-1:0] multipath_result_i,
	input  wire logic [tuner_regs_pkg::MEAS_W-1:0] fieldstrength_result_i,
	input  wire logic                             if_outside_i,
	input  wire logic                             if_below_i,
	// Configuration to the analog section
	output logic                                  crystal_aux_out_enable_o,
	output logic                                  lo_divide_select_o,
	output logic                                  prestage_gain_threshold_hi_o,
	output logic                                  prestage_gain_threshold_lo_o,
	output logic [3:0]                            crystal_load_trim_o,
	output logic [3:0]                            if_gain_code_o,
	output logic [tuner_regs_pkg::MEAS_W-1:0]      fieldstrength_threshold_o,
	output logic [tuner_regs_pkg::MEAS_W-1:0]      multipath_threshold_o,
	// Comparator flags
	output logic                                  fieldstrength_above_o,
	output logic                                  multipath_above_o
);
	import tuner_regs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		frame_st_t          st;
		logic               scl_q;
		logic [7:0]         addr;
		logic [SHIFT_W-1:0] shreg;
		logic [4:0]         nbits;
		logic [7:0]         special;
		logic [3:0]         gain;
		logic [MEAS_W-1:0]  fs_thr;
		logic [MEAS_W-1:0]  mp_thr;
		logic [15:0]        result;
		logic [7:0]         misc;
		logic               dout;
		logic               dout_en;
	} state_t;

	localparam state_t RST_STATE = '{
		st:      ST_IDLE,
		scl_q:   1'b0,
		addr:    8'h00,
		shreg:   '0,
		nbits:   5'h00,
		special: RST_SPECIAL,
		gain:    RST_GAIN,
		fs_thr:  RST_THR,
		mp_thr:  RST_THR,
		result:  16'h0000,
		misc:    8'h00,
		dout:    1'b0,
		dout_en: 1'b0
	};

	state_t r;
	state_t n;

	bus_lines_if lines ();

	bus_spike_filter u_filter (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.scl_i  (scl_i),
		.sda_i  (sda_i),
		.ena_i  (bus_frame_enable_i),
		.lines  (lines)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	logic               scl_rise;
	logic               scl_fall;
	logic               commit;
	logic [7:0]         addr_byte;
	logic [SHIFT_W-1:0] read_word;
	logic               below_q;

	assign scl_rise  = lines.scl & ~r.scl_q;
	assign scl_fall  = ~lines.scl & r.scl_q;
	assign commit    = (r.st == ST_WDATA) && !lines.ena;
	assign addr_byte = {r.shreg[6:0], lines.sda};
	// Direction only meaningful while outside the window
	assign below_q   = if_outside_i & if_below_i;

	always_comb begin
		n       = r;
		n.scl_q = lines.scl;

		// Live results, refreshed every cycle
		n.result[RES_BELOW_BIT]                 = below_q;
		n.result[RES_OUT_BIT]                   = if_outside_i;
		n.result[THR_FS_HI:THR_FS_LO]           = multipath_result_i;
		n.result[THR_MP_HI:THR_MP_LO]           = fieldstrength_result_i;
		n.misc[MISC_BELOW_BIT]                  = below_q;
		n.misc[MISC_OUT_BIT]                    = if_outside_i;
		n.misc[MISC_FS_BIT]                     = fieldstrength_result_i > r.fs_thr;
		n.misc[MISC_MP_BIT]                     = multipath_result_i > r.mp_thr;
		n.misc[3:0]                             = MISC_RSVD;

		// Read data, zero for unmapped addresses
		unique case (addr_byte)
			ADDR_RESULT: read_word = {r.result, r.misc};
			ADDR_MISC:   read_word = {r.misc, 16'h0000};
			default:     read_word = '0;
		endcase

		if (!lines.ena) begin
			// Writes take effect only at frame end, so a cut frame changes nothing
			if (commit) begin
				unique case (r.addr)
					ADDR_SPECIAL: begin
						if (r.nbits == BYTE_BITS) begin
							n.special = r.shreg[7:0];
						end
					end
					ADDR_IF_GAIN: begin
						if (r.nbits == BYTE_BITS) begin
							n.gain = r.shreg[GAIN_HI:GAIN_LO];
						end
					end
					ADDR_THRESH: begin
						if (r.nbits == WORD_BITS) begin
							n.fs_thr = r.shreg[THR_FS_HI:THR_FS_LO];
							n.mp_thr = r.shreg[THR_MP_HI:THR_MP_LO];
						end
					end
					default: begin
					end
				endcase
			end
			n.st      = ST_IDLE;
			n.nbits   = 5'h00;
			n.dout    = 1'b0;
			n.dout_en = 1'b0;
		end else begin
			unique case (r.st)
				ST_IDLE: begin
					n.st    = ST_ADDR;
					n.nbits = 5'h00;
				end
				ST_ADDR: begin
					if (scl_rise) begin
						n.shreg = {r.shreg[SHIFT_W-2:0], lines.sda};
						n.nbits = r.nbits + 1'b1;
						if (r.nbits == ADDR_BITS - 1'b1) begin
							n.addr  = addr_byte;
							n.nbits = 5'h00;
							if (addr_byte[ADDR_RD_BIT]) begin
								// Snapshot for the read; no state is disturbed
								n.shreg   = read_word;
								n.dout    = read_word[SHIFT_W-1];
								n.dout_en = 1'b1;
								n.st      = ST_RDATA;
							end else begin
								n.st = ST_WDATA;
							end
						end
					end
				end
				ST_WDATA: begin
					// Bits past the seventeenth are dropped; any bit beyond a word spoils the commit
					if (scl_rise && r.nbits <= WORD_BITS) begin
						n.shreg = {r.shreg[SHIFT_W-2:0], lines.sda};
						n.nbits = r.nbits + 1'b1;
					end
				end
				ST_RDATA: begin
					// First fall ends the address clock and keeps the MSB for the ninth rise
					if (scl_fall) begin
						n.shreg = {r.shreg[SHIFT_W-2:0], 1'b0};
						n.dout  = r.shreg[SHIFT_W-1];
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			r <= RST_STATE;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign data_out_o                   = r.dout;
	assign data_out_en_o                = r.dout_en;
	assign crystal_aux_out_enable_o     = r.special[SP_AUX_BIT];
	assign lo_divide_select_o           = r.special[SP_LO_BIT];
	assign prestage_gain_threshold_hi_o = r.special[SP_AGC_HI];
	assign prestage_gain_threshold_lo_o = r.special[SP_AGC_LO];
	assign crystal_load_trim_o          = r.special[SP_TRIM_HI:SP_TRIM_LO];
	assign if_gain_code_o               = r.gain;
	assign fieldstrength_threshold_o    = r.fs_thr;
	assign multipath_threshold_o        = r.mp_thr;
	assign fieldstrength_above_o        = r.misc[MISC_FS_BIT];
	assign multipath_above_o            = r.misc[MISC_MP_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	a_fs_compare: assert property (
		r.misc[MISC_FS_BIT] == ($past(fieldstrength_result_i) > $past(r.fs_thr)))
		else $error("field strength flag wrong");

	a_mp_compare: assert property (
		r.misc[MISC_MP_BIT] == ($past(multipath_result_i) > $past(r.mp_thr)))
		else $error("multipath flag wrong");

	a_result_layout: assert property (
		r.result[THR_FS_HI:THR_FS_LO] == $past(multipath_result_i))
		else $error("multipath result misplaced");

	a_fs_layout: assert property (
		r.result[THR_MP_HI:THR_MP_LO] == $past(fieldstrength_result_i))
		else $error("field strength result misplaced");

	a_window_word: assert property (
		r.result[RES_OUT_BIT] == $past(if_outside_i) &&
		(!r.result[RES_OUT_BIT] || r.result[RES_BELOW_BIT] == $past(if_below_i)))
		else $error("window status in result word wrong");

	a_window_misc: assert property (
		r.misc[MISC_OUT_BIT] == r.result[RES_OUT_BIT] &&
		r.misc[MISC_BELOW_BIT] == r.result[RES_BELOW_BIT])
		else $error("misc window status differs from result word");

	a_misc_reserved: assert property (
		r.misc[3:0] == MISC_RSVD && !(r.result[RES_BELOW_BIT] && !r.result[RES_OUT_BIT]))
		else $error("reserved result bits not zero");

	a_special_commit: assert property (
		(commit && r.addr == ADDR_SPECIAL && r.nbits == BYTE_BITS)
		|=> r.special == $past(r.shreg[7:0]) && crystal_load_trim_o == $past(r.shreg[3:0]))
		else $error("specials byte not stored");

	a_gain_commit: assert property (
		(commit && r.addr == ADDR_IF_GAIN && r.nbits == BYTE_BITS)
		|=> if_gain_code_o == $past(r.shreg[GAIN_HI:GAIN_LO]))
		else $error("gain code not stored");

	a_config_hold: assert property (
		!commit |=> $stable(r.special) && $stable(r.gain) && $stable(r.fs_thr) && $stable(r.mp_thr))
		else $error("configuration changed outside a write commit");

	a_read_nochange: assert property (
		(r.st == ST_RDATA) |=> $stable(r.special) && $stable(r.mp_thr))
		else $error("read disturbed configuration");

	a_thresh_commit: assert property (
		(commit && r.addr == ADDR_THRESH && r.nbits == WORD_BITS)
		|=> fieldstrength_threshold_o == $past(r.shreg[THR_FS_HI:THR_FS_LO]) &&
		multipath_threshold_o == $past(r.shreg[THR_MP_HI:THR_MP_LO]))
		else $error("threshold word not stored");

	a_refused_gain: assert property (
		(commit && r.addr == ADDR_IF_GAIN && r.nbits != BYTE_BITS) |=> $stable(r.gain))
		else $error("gain stored from a frame of wrong length");

	a_read_first: assert property (
		(lines.ena && r.st == ST_ADDR && scl_rise &&
		 r.nbits == ADDR_BITS - 1'b1 && addr_byte[ADDR_RD_BIT])
		|=> data_out_en_o && data_out_o == $past(read_word[SHIFT_W-1]))
		else $error("read word MSB not presented");

	a_read_shift: assert property (
		(lines.ena && r.st == ST_RDATA && scl_fall) |=> data_out_o == $past(r.shreg[SHIFT_W-1]))
		else $error("read bit order wrong");

endmodule : tuner_config_result_regs

`default_nettype wire

// ### tuner_host.sv
// Host-side model of the three-wire serial master
`timescale 1ns/1ps
`default_nettype none

module tuner_host (
	// Clock
	input  wire logic        mclk_i,
	// Bus pins toward the device
	output var  logic        scl_o,
	output var  logic        sda_o,
	output var  logic        ena_o,
	input  wire logic        data_out_i,
	input  wire logic        data_out_en_i,
	// Captured read word
	output var  logic        rd_done_o,
	output var  logic [23:0] rd_word_o
);
	initial begin
		scl_o = 1'b0;
		sda_o = 1'b0;
		ena_o = 1'b0;
		rd_done_o = 1'b0;
		rd_word_o = 24'h0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : step

	// Phases of 8 clocks stay well clear of the 5-cycle pin filter
	task automatic xfer(input logic [31:0] bits, input int n, input bit spike);
		logic [23:0] cap;
		cap = 24'h0;
		ena_o = 1'b1;
		step(12);
		for (int i = 0; i < n; i++) begin
			sda_o = bits[31-i];
			step(3);
			if (spike) begin
				scl_o = 1'b1;
				step(1);
				scl_o = 1'b0;
			end
			step(5);
			scl_o = 1'b1;
			step(8);
			// Undriven read data must not pass for a good bit
			if (i >= 8)
				cap[31-i] = data_out_en_i ? data_out_i : 1'bx;
			scl_o = 1'b0;
		end
		step(8);
		ena_o = 1'b0;
		step(12);
		if (n == 32) begin
			rd_word_o = cap;
			rd_done_o = 1'b1;
			step(1);
			rd_done_o = 1'b0;
		end
	endtask : xfer
endmodule : tuner_host

`default_nettype wire

// ### test_tuner_config_result_regs.sv
// Self-checking bench for the tuner configuration and result registers
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end

module test_tuner_config_result_regs;
	import tuner_regs_pkg::*;
	logic        mclk, nrst, scl, sda, ena, dout, dout_en, outside, below;
	logic        aux, lo, thr_hi, thr_lo, fs_above, mp_above, rd_done;
	logic [3:0]  trim, gain;
	logic [6:0]  mp, fs, fthr, mthr;
	logic [23:0] rd_word, exp_w;
	logic [23:0] exp_q[$];
	int          n_fail = 0;
	int          n_compared = 0;

	initial mclk = 1'b0;
	always #20 mclk = ~mclk;

	tuner_config_result_regs tuner_config_result_regs_inst (
		.mclk_i(mclk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda), .bus_frame_enable_i(ena),
		.data_out_o(dout), .data_out_en_o(dout_en), .multipath_result_i(mp),
		.fieldstrength_result_i(fs), .if_outside_i(outside), .if_below_i(below),
		.crystal_aux_out_enable_o(aux), .lo_divide_select_o(lo),
		.prestage_gain_threshold_hi_o(thr_hi), .prestage_gain_threshold_lo_o(thr_lo),
		.crystal_load_trim_o(trim), .if_gain_code_o(gain), .fieldstrength_threshold_o(fthr),
		.multipath_threshold_o(mthr), .fieldstrength_above_o(fs_above),
		.multipath_above_o(mp_above));

	tuner_host tuner_host_inst (
		.mclk_i(mclk), .scl_o(scl), .sda_o(sda), .ena_o(ena), .data_out_i(dout),
		.data_out_en_i(dout_en), .rd_done_o(rd_done), .rd_word_o(rd_word));

	task automatic conclude;
		if (n_fail == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	// Data is left aligned so a 9-bit frame is just a longer count
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input int nb, input bit sp);
		tuner_host_inst.xfer({a, d, 8'h0}, 8 + nb, sp);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [23:0] e);
		exp_q.push_back(e);
		tuner_host_inst.xfer({a, 24'h0}, 32, 1'b0);
	endtask : rd

	always @(posedge mclk) begin
		if (rd_done === 1'b1) begin
			exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 24'hx;
			`CHK("read word", exp_w, rd_word)
		end
	end

	initial begin
		repeat (100000) @(posedge mclk);
		n_fail++;
		conclude();
	end

	initial begin
		logic [7:0]  d, misc;
		logic [15:0] w;
		logic [6:0]  ft, mt;
		nrst = 1'b0;
		mp = 7'h00;
		fs = 7'h00;
		outside = 1'b0;
		below = 1'b0;
		void'($urandom(12));
		repeat (10) @(posedge mclk);
		#1 nrst = 1'b1;
		repeat (3) @(posedge mclk);
		`CHK("reset cfg", 26'h0, {aux, lo, thr_hi, thr_lo, trim, gain, fthr, mthr})
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			d[5:4] = i[1:0];
			d[3:0] = 4'(i * 5);
			wr(ADDR_SPECIAL, {d, 8'h0}, 8, i == 2);
			`CHK("special", d, {aux, lo, thr_hi, thr_lo, trim})
			d = 8'($urandom);
			d[3:0] = (i == 0) ? 4'h0 : (i == 1) ? 4'h4 : (i == 2) ? 4'hb : 4'hf;
			wr(ADDR_IF_GAIN, {d, 8'h0}, 8, 1'b0);
			`CHK("gain", d[3:0], gain)
		end
		// A frame with a stray ninth data bit must leave the gain alone
		wr(ADDR_IF_GAIN, 16'h0, 9, 1'b0);
		`CHK("gain kept", 4'hf, gain)
		w = 16'($urandom);
		ft = w[14:8];
		mt = w[6:0];
		wr(ADDR_THRESH, w, 16, 1'b0);
		`CHK("thresholds", {ft, mt}, {fthr, mthr})
		for (int k = 0; k < 6; k++) begin
			outside = (k % 3) != 0;
			below = (k % 3 == 1) || (k == 3);
			fs = (k < 2) ? ft : 7'($urandom);
			mp = (k == 2 || k == 3) ? mt : 7'($urandom);
			repeat (3) @(posedge mclk);
			#1;
			`CHK("fs above", fs > ft, fs_above)
			`CHK("mp above", mp > mt, mp_above)
			misc = {outside & below, outside, fs > ft, mp > mt, 4'h0};
			rd(ADDR_RESULT, {outside & below, mp, outside, fs, misc});
			rd(ADDR_MISC, {misc, 16'h0});
		end
		rd(8'h84, 24'h0);
		repeat (5) @(posedge mclk);
		`CHK("reads left", 0, exp_q.size())
		conclude();
	end
endmodule : test_tuner_config_result_regs

`default_nettype wire
